// *** port_pattern_interrupt.sv ***
// port pattern match interrupt unit with axi4-lite register slave
`timescale 1ns/1ps
`include "port_match_cfg.svh"
module port_pattern_interrupt #(
    parameter int PORT_W = 8
) (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic [PORT_W-1:0] PORT_PINS_I,
    input wire logic [3:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [3:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic IRQ_O,
    output logic WAKE_O
);
    // port width must fit the low byte lane of a register word
    // refused while the design is built, before any logic runs
    if (PORT_W < 1 || PORT_W > 8) begin : g_bad_width
        $error("PORT_W must be 1 to 8");
    end

    // pin synchroniser stages; stage one feeds only stage two
    logic [PORT_W-1:0] sync1_q;
    logic [PORT_W-1:0] sync2_q;
    // software settings
    logic [PORT_W-1:0] key_pin_mask_q;
    logic [PORT_W-1:0] key_match_pattern_q;
    port_match_pkg::ctrl_s ctrl_q;
    // qualification counter
    logic [3:0] hold_cnt_q;
    logic cond;
    logic qualified;
    // axi pending write halves
    logic aw_have_q;
    logic w_have_q;
    port_match_pkg::wr_req_s wr_q;
    logic wr_fire;
    logic clr_flag;

    // two-flop synchroniser on the port pins
    // reset low is harmless: the mask is empty until software sets it
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= PORT_PINS_I;
            sync2_q <= sync1_q;
        end
    end

    // masked compare; masked-off pins contribute nothing
    always_comb begin
        logic differ;
        differ = |((sync2_q ^ key_match_pattern_q) & key_pin_mask_q);
        // polarity set: any enabled pin differing counts, e.g. a key low
        cond = ctrl_q.polarity ? differ : !differ;
        // an empty mask never triggers, even in equal mode
        cond = cond && ctrl_q.active && (|key_pin_mask_q);
    end

    // condition must stand longer than six core clocks
    // saturating, so a standing condition qualifies only once
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            hold_cnt_q <= '0;
        end else if (!cond) begin
            hold_cnt_q <= '0;
        end else if (hold_cnt_q != 4'(`PM_QUAL_CNT)) begin
            hold_cnt_q <= hold_cnt_q + 4'h1;
        end
    end

    // pulse once in the clock where the count stands one below its saturating target
    assign qualified = cond && (hold_cnt_q == 4'(`PM_QUAL_CNT - 1));

    // write takes when both halves are held
    assign wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID_O;
    // writing one to the flag bit clears it
    assign clr_flag = wr_fire && wr_q.addr == `PM_ADDR_CTRL && wr_q.strb[0]
        && wr_q.data[`PM_CTRL_FLAG];

    // axi write address and data capture, in either order
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_q <= '0;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_have_q <= 1'b1;
                wr_q.addr <= S_AXI_AWADDR_I;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_have_q <= 1'b1;
                wr_q.data <= S_AXI_WDATA_I;
                wr_q.strb <= S_AXI_WSTRB_I;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // ready only while a half is missing and no response waits
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
        end else begin
            S_AXI_AWREADY_O <= !aw_have_q && !(S_AXI_AWVALID_I
                && S_AXI_AWREADY_O) && !S_AXI_BVALID_O && !wr_fire;
            S_AXI_WREADY_O <= !w_have_q && !(S_AXI_WVALID_I
                && S_AXI_WREADY_O) && !S_AXI_BVALID_O && !wr_fire;
        end
    end

    // write response; unmapped addresses get slverr
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= `PM_RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID_O <= 1'b1;
            // only the three settings words take a write
            S_AXI_BRESP_O <= (wr_q.addr == `PM_ADDR_MASK
                || wr_q.addr == `PM_ADDR_PATN
                || wr_q.addr == `PM_ADDR_CTRL) ? `PM_RESP_OKAY
                : `PM_RESP_SLVERR;
        end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    // settings registers, low byte lane only; the flag shares the word,
    // so one process owns the whole control image
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            key_pin_mask_q <= PORT_W'(`PM_MASK_RST);
            key_match_pattern_q <= PORT_W'(`PM_PATN_RST);
            ctrl_q.active <= 1'b0;
            ctrl_q.irq_en <= 1'b0;
            ctrl_q.polarity <= 1'b0;
            ctrl_q.flag <= 1'b0;
        end else begin
            // sticky match flag; a new match wins over a clear
            if (qualified) begin
                ctrl_q.flag <= 1'b1;
            end else if (clr_flag) begin
                ctrl_q.flag <= 1'b0;
            end
            if (wr_fire && wr_q.strb[0]) begin
                unique case (wr_q.addr)
                    `PM_ADDR_MASK: key_pin_mask_q <= wr_q.data[PORT_W-1:0];
                    `PM_ADDR_PATN:
                        key_match_pattern_q <= wr_q.data[PORT_W-1:0];
                    `PM_ADDR_CTRL: begin
                        ctrl_q.active <= wr_q.data[`PM_CTRL_ACT];
                        ctrl_q.irq_en <= wr_q.data[`PM_CTRL_IEN];
                        ctrl_q.polarity <= wr_q.data[`PM_CTRL_POL];
                    end
                    default: begin
                        // read-only or unmapped: nothing stored
                    end
                endcase
            end
        end
    end

    // interrupt request and wake from idle or power-down
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            IRQ_O <= 1'b0;
            WAKE_O <= 1'b0;
        end else begin
            IRQ_O <= ctrl_q.flag && ctrl_q.irq_en;
            WAKE_O <= ctrl_q.flag && ctrl_q.irq_en;
        end
    end

    // read channel, one beat at a time
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= '0;
            S_AXI_RRESP_O <= `PM_RESP_OKAY;
        end else if (S_AXI_RVALID_O) begin
            S_AXI_ARREADY_O <= 1'b0;
            if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RRESP_O <= `PM_RESP_OKAY;
            S_AXI_RDATA_O <= '0;
            unique case (S_AXI_ARADDR_I)
                `PM_ADDR_MASK: S_AXI_RDATA_O[PORT_W-1:0] <= key_pin_mask_q;
                `PM_ADDR_PATN:
                    S_AXI_RDATA_O[PORT_W-1:0] <= key_match_pattern_q;
                `PM_ADDR_CTRL: S_AXI_RDATA_O[3:0] <= ctrl_q;
                `PM_ADDR_PORT: S_AXI_RDATA_O[PORT_W-1:0] <= sync2_q;
                default: S_AXI_RRESP_O <= `PM_RESP_SLVERR;
            endcase
        end else begin
            S_AXI_ARREADY_O <= 1'b1;
        end
    end
endmodule

// *** port_match_cfg.svh ***
// register offsets, field positions, reset values and timing for port match
`ifndef PORT_MATCH_CFG_SVH
`define PORT_MATCH_CFG_SVH
// register byte addresses
`define PM_ADDR_MASK 4'h0
`define PM_ADDR_PATN 4'h4
`define PM_ADDR_CTRL 4'h8
`define PM_ADDR_PORT 4'hc
// control register fields
`define PM_CTRL_FLAG 0
`define PM_CTRL_POL 1
`define PM_CTRL_IEN 2
`define PM_CTRL_ACT 3
// reset values
`define PM_MASK_RST 8'h00
`define PM_PATN_RST 8'hff
// qualification: held longer than six core clocks
`define PM_HOLD_CLKS 6
`define PM_QUAL_CNT (`PM_HOLD_CLKS + 1)
// axi response codes
`define PM_RESP_OKAY 2'b00
`define PM_RESP_SLVERR 2'b10
`endif

// *** port_match_pkg.sv ***
// types shared by the port pattern match unit
package port_match_pkg;
    // control register image
    typedef struct packed {
        logic active;
        logic irq_en;
        logic polarity;
        logic flag;
    } ctrl_s;
    // axi write address plus data pending
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_s;
endpackage

// *** port_match_monitor.sv ***
// checker for bus handshakes and interrupt outputs of the match unit
`timescale 1ns/1ps
module port_match_monitor (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic IRQ_O,
    input wire logic WAKE_O
);
    // one domain, so one clock and reset for all
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    wake_tracks_irq_a: assert property (WAKE_O == IRQ_O)
        else $error("wake differs from irq");
    b_retire_a: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I
        |=> !S_AXI_BVALID_O) else $error("write answer repeated");
    r_retire_a: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I
        |=> !S_AXI_RVALID_O) else $error("read answer repeated");
    r_latency_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
        |=> S_AXI_RVALID_O) else $error("read answer late");
    b_latency_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
        S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##[1:2] S_AXI_BVALID_O)
        else $error("write answer late");
    w_refused_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O &&
        !S_AXI_WREADY_O) else $error("write taken while answer pending");
    ar_refused_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
        |=> !S_AXI_ARREADY_O) else $error("read taken while pending");
    r_upper_a: assert property (S_AXI_RVALID_O |->
        S_AXI_RDATA_O[31:8] == 24'h0) else $error("upper read bits set");
endmodule
bind port_pattern_interrupt port_match_monitor u_mon (.*);

// *** port_keypad.sv ***
// keypad model: a pressed key pulls its pin low, pull-ups do the rest
`timescale 1ns/1ps
module port_keypad (
    input wire logic [7:0] press_i,
    output logic [7:0] pins_o
);
    // no bounce modelled; press length is set by the bench
    assign pins_o = ~press_i;
endmodule

// *** port_pattern_match_irq_bench.sv ***
// self-checking bench for the port pattern match unit
`timescale 1ns/1ps
module port_pattern_match_irq_bench;
    logic clk, rst_n, awv, wv, bready, arv, rready, f;
    logic awready, wready, bvalid, arready, rvalid, irq, wake;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] press, pins, mask, pat, keys;
    int miscompares = 0;
    int checks = 0;
    // read map probes and trial settings
    logic [3:0] ad[5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
    logic [7:0] ex[5] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
    logic [3:0] ct[6] = '{4'he, 4'he, 4'he, 4'ha, 4'h6, 4'hc};
    int hd[6] = '{20, 6, 20, 7, 20, 20};
    port_keypad u_keys (.press_i(press), .pins_o(pins));
    port_pattern_interrupt DUT (.CLK_I(clk), .RESET_N_I(rst_n),
        .PORT_PINS_I(pins), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf),
        .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
        .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .IRQ_O(irq), .WAKE_O(wake));
    // 100 MHz core clock
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task conclude;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one write; each half released when taken, waits are bounded
    task wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awv && awready) awv <= 0;
            if (wv && wready) wv <= 0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 0;
        if (n == 40) begin miscompares++; conclude(); end
    endtask
    task rdr(input logic [3:0] a);
        int n;
        @(posedge clk);
        araddr <= a; arv <= 1; rready <= 1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arv && arready) arv <= 0;
            if (rvalid) break;
        end
        rd = rdata; rs = rresp;
        rready <= 0;
        if (n == 40) begin miscompares++; conclude(); end
    endtask
    // reference: masked compare, polarity, active, held over six clocks
    function automatic logic flag_of(logic [7:0] m, logic [7:0] p,
        logic [7:0] pn, logic [3:0] c, int h);
        logic [7:0] d;
        d = (pn ^ p) & m;
        return c[3] && m != 0 && (c[1] ? d != 0 : d == 0) && h > 6;
    endfunction
    initial begin
        rst_n = 0; awv = 0; wv = 0; bready = 0; arv = 0; rready = 0;
        awaddr = 0; araddr = 0; wdata = 0; press = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1;
        void'($urandom(48361));
        for (int i = 0; i < 5; i++) begin
            rdr(ad[i]);
            chk(rd, {24'h0, ex[i]});
            chk({30'h0, rs}, i == 4 ? 32'h2 : 32'h0);
        end
        wr(4'hc, 32'h55);
        chk({30'h0, rs}, 32'h2);
        wr(4'h2, 32'h55);
        chk({30'h0, rs}, 32'h2);
        // walk polarity, enable, active, hold and mask cases
        for (int i = 0; i < 6; i++) begin
            mask = 8'($urandom) & 8'h7f | 8'h01;
            pat = i == 5 ? 8'($urandom) & 8'hfe : 8'hff;
            keys = i == 2 ? 8'h80 : i == 5 ? pat ^ mask
                : mask & (~mask + 8'h1);
            wr(4'h8, 32'h0);
            wr(4'h0, {24'h0, mask});
            wr(4'h4, {24'h0, pat});
            wr(4'h8, {28'h0, ct[i] | 4'h1});
            press <= keys;
            repeat (hd[i]) @(posedge clk);
            press <= 0;
            repeat (12) @(posedge clk);
            f = flag_of(mask, pat, ~keys, ct[i], hd[i]);
            rdr(4'h8);
            chk(rd, {28'h0, ct[i] & 4'he | {3'h0, f}});
            chk({31'h0, irq}, {31'h0, f & ct[i][2]});
            chk({31'h0, wake}, {31'h0, f & ct[i][2]});
            wr(4'h8, {28'h0, ct[i] | 4'h1});
            rdr(4'h8);
            chk(rd, {28'h0, ct[i] & 4'he});
        end
        conclude();
    end
endmodule
